// file: ffu_flag_core.sv
// Soft FIFO with flag update timing per mode, and a Wishbone register port.
// Assumes one clock; user write and read ports are synchronous to it.
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module ffu_flag_core import ffu_pkg::*; (
  // Clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic CORE_CE,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Write side
  input wire logic WR_EN,
  input wire logic [DATA_W-1:0] WR_DATA,
  output ffu_wflags_type WR_FLAGS,
  output logic [PTR_W-1:0] WR_FILL,
  // Read side
  input wire logic RD_EN,
  output logic [DATA_W-1:0] RD_DATA,
  output ffu_rflags_type RD_FLAGS,
  output logic [PTR_W-1:0] RD_FILL
);

  // ==========================================================
  // Declarations
  ffu_mode_type mode_q;                       // Operating mode
  logic [PTR_W-1:0] thr_full_lvl_q;           // Threshold full level
  logic [PTR_W-1:0] thr_empty_lvl_q;          // Threshold empty level
  logic ack_q;                                // Bus acknowledge
  logic [31:0] dat_q;                         // Bus read data
  logic [31:0] rdata;                         // Decoded read value
  logic bus_req;                              // Cycle in progress
  logic bus_wr;                               // Write takes effect
  logic flush_w;                              // Control write empties FIFO
  logic clr;                                  // Reset or flush
  logic look;                                 // Lookahead selected
  logic indep;                                // Independent view selected
  logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;       // Write pointer
  logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;       // RAM read pointer
  logic [PTR_W-1:0] rd_sync, wr_sync;         // Crossed pointers
  logic [PTR_W-1:0] rd_view, wr_view;         // Pointers each side sees
  logic [PTR_W-1:0] fcnt_d, fcnt_q;           // Write-side occupancy
  logic [PTR_W-1:0] ecnt_d;                   // Read-side RAM occupancy
  logic [PTR_W-1:0] tot_d, tot_q;             // Read-side total words
  logic wr_ok;                                // Accepted write
  logic rd_std;                               // Accepted standard read
  logic take_out;                             // Lookahead word consumed
  logic out_load;                             // Prefetch moves to output
  logic f1_load;                              // RAM word into prefetch
  logic rd_adv;                               // RAM pointer advances
  logic rd_acc;                               // Any accepted read
  logic f1_v_q, f1_v_d;                       // Prefetch holds a word
  logic o_v_q, o_v_d;                         // Output holds a word
  logic [DATA_W-1:0] f1_data_q;               // Prefetch word
  logic [DATA_W-1:0] ram_q;                   // RAM head word
  ffu_wflags_type wflags_q;                   // Write-side flags
  ffu_rflags_type rflags_q;                   // Read-side flags
  logic [PTR_W-1:0] wr_fill_q, rd_fill_q;     // Fill levels
  logic [DATA_W-1:0] rd_data_q;               // Read data register

  // ==========================================================
  // Wishbone slave
  assign bus_req = WB_CYC_I & WB_STB_I;
  // Writes land at the edge where the master sees ack
  assign bus_wr = CORE_CE & bus_req & WB_WE_I & ack_q;
  assign flush_w = bus_wr & (WB_ADR_I == REG_CTRL) & WB_SEL_I[0];
  assign clr = SYS_RST | flush_w;

  // Acknowledge one cycle after the strobe, drop after one
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else if (CORE_CE) begin
      ack_q <= bus_req & ~ack_q;
      if (bus_req && !ack_q) begin
        dat_q <= rdata;
      end
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    rdata = '0;
    if (WB_ADR_I == REG_CTRL) begin
      rdata[MODE_LSB +: 3] = mode_q;
    end else if (WB_ADR_I == REG_THRESH) begin
      rdata[THR_FULL_LSB +: PTR_W] = thr_full_lvl_q;
      rdata[THR_EMPTY_LSB +: PTR_W] = thr_empty_lvl_q;
    end else if (WB_ADR_I == REG_STATUS) begin
      rdata[STAT_WFLAGS_LSB +: $bits(ffu_wflags_type)] = wflags_q;
      rdata[STAT_RFLAGS_LSB +: $bits(ffu_rflags_type)] = rflags_q;
    end else if (WB_ADR_I == REG_FILL) begin
      rdata[FILL_WR_LSB +: PTR_W] = wr_fill_q;
      rdata[FILL_RD_LSB +: PTR_W] = rd_fill_q;
    end
  end

  // Configuration; a mode change also flushes so no pointer goes stale
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mode_q <= FFU_MODE_STD;
      thr_full_lvl_q <= THR_FULL_RST;
      thr_empty_lvl_q <= THR_EMPTY_RST;
    end else if (bus_wr) begin
      if (WB_ADR_I == REG_CTRL && WB_SEL_I[0]) begin
        case (WB_DAT_I[MODE_LSB +: 3])
          FFU_MODE_LOOK: mode_q <= FFU_MODE_LOOK;
          FFU_MODE_INDEP: mode_q <= FFU_MODE_INDEP;
          default: mode_q <= FFU_MODE_STD;  // Bad codes fall back
        endcase
      end else if (WB_ADR_I == REG_THRESH) begin
        if (WB_SEL_I[0]) begin
          thr_full_lvl_q <= WB_DAT_I[THR_FULL_LSB +: PTR_W];
        end
        if (WB_SEL_I[1]) begin
          thr_empty_lvl_q <= WB_DAT_I[THR_EMPTY_LSB +: PTR_W];
        end
      end
    end
  end

  // ==========================================================
  // Handshakes and pointer motion
  assign look = (mode_q == FFU_MODE_LOOK);
  assign indep = (mode_q == FFU_MODE_INDEP);
  assign wr_ok = CORE_CE & WR_EN & ~wflags_q.full;
  assign rd_std = CORE_CE & ~look & RD_EN & ~rflags_q.empty;
  // In lookahead the shown word is consumed; empty mirrors output
  assign take_out = CORE_CE & look & RD_EN & o_v_q;
  assign out_load = CORE_CE & look & f1_v_q & (~o_v_q | take_out);
  assign f1_load = CORE_CE & look & (wr_ptr_q != rd_ptr_q) & (~f1_v_q | out_load);
  assign rd_adv = look ? f1_load : rd_std;
  assign rd_acc = look ? take_out : rd_std;
  assign f1_v_d = f1_load | (f1_v_q & ~out_load);
  assign o_v_d = out_load | (o_v_q & ~take_out);
  assign wr_ptr_d = wr_ptr_q + PTR_W'(wr_ok);
  assign rd_ptr_d = rd_ptr_q + PTR_W'(rd_adv);

  // Pointers crossing to the far side
  ffu_ptr_sync u_rd_to_wr (
    .clk(CORE_CLK),
    .clr(clr),
    .ce(CORE_CE),
    .ptr_bin(rd_ptr_d),
    .ptr_sync(rd_sync)
  );

  ffu_ptr_sync u_wr_to_rd (
    .clk(CORE_CLK),
    .clr(clr),
    .ce(CORE_CE),
    .ptr_bin(wr_ptr_d),
    .ptr_sync(wr_sync)
  );

  // Common modes see the other pointer at once, independent via the chain
  assign rd_view = indep ? rd_sync : rd_ptr_d;
  assign wr_view = indep ? wr_sync : wr_ptr_d;
  assign fcnt_d = wr_ptr_d - rd_view;
  assign ecnt_d = wr_view - rd_ptr_d;
  assign tot_d = look ? ecnt_d + PTR_W'(f1_v_d) + PTR_W'(o_v_d) : ecnt_d;

  // Storage
  ffu_ram u_ram (
    .clk(CORE_CLK),
    .ce(CORE_CE),
    .we(wr_ok),
    .waddr(wr_ptr_q[ADDR_W-1:0]),
    .wdata(WR_DATA),
    .raddr(rd_ptr_q[ADDR_W-1:0]),
    .rdata(ram_q)
  );

  // Pointers and counts
  always_ff @(posedge CORE_CLK) begin
    if (clr) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fcnt_q <= '0;
      tot_q <= '0;
    end else if (CORE_CE) begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      fcnt_q <= fcnt_d;
      tot_q <= tot_d;
    end
  end

  // ==========================================================
  // Read data path; lookahead keeps a two-stage prefetch
  always_ff @(posedge CORE_CLK) begin
    if (clr) begin
      f1_v_q <= 1'b0;
      o_v_q <= 1'b0;
      f1_data_q <= '0;
      rd_data_q <= '0;
    end else if (CORE_CE) begin
      f1_v_q <= f1_v_d;
      o_v_q <= o_v_d;
      if (f1_load) begin
        f1_data_q <= ram_q;
      end
      if (out_load) begin
        rd_data_q <= f1_data_q;
      end else if (rd_std) begin
        rd_data_q <= ram_q;
      end
    end
  end

  // ==========================================================
  // Write-side flags: all but threshold full registered at the operation edge itself
  always_ff @(posedge CORE_CLK) begin
    if (clr) begin
      wflags_q <= WFLAGS_RST;
      wr_fill_q <= '0;
    end else if (CORE_CE) begin
      wflags_q.full <= (fcnt_d == DEPTH_CNT);
      wflags_q.near_full <= (fcnt_d >= NEAR_FULL_CNT);
      // One edge behind, from the stored count
      wflags_q.thr_full <= (fcnt_q >= thr_full_lvl_q);
      wflags_q.wr_ack <= wr_ok;
      wflags_q.overflow <= CORE_CE & WR_EN & wflags_q.full;
      // Independent fill trails the pointer by one edge
      if (indep) begin
        wr_fill_q <= wr_ptr_q - rd_sync;
      end else begin
        wr_fill_q <= tot_d;
      end
    end
  end

  // ==========================================================
  // Read-side flags
  always_ff @(posedge CORE_CLK) begin
    if (clr) begin
      rflags_q <= RFLAGS_RST;
      rd_fill_q <= '0;
    end else if (CORE_CE) begin
      // Lookahead empty follows the output stage, two edges after a write
      if (look) begin
        rflags_q.empty <= ~o_v_d;
      end else begin
        rflags_q.empty <= (ecnt_d == '0);
      end
      // Lookahead writes reach near empty one edge late
      if (look && !take_out) begin
        rflags_q.near_empty <= (tot_q <= NEAR_EMPTY_CNT);
      end else begin
        rflags_q.near_empty <= (tot_d <= NEAR_EMPTY_CNT);
      end
      rflags_q.thr_empty <= (tot_q <= thr_empty_lvl_q);
      rflags_q.valid <= rd_acc;
      rflags_q.underflow <= CORE_CE & RD_EN & rflags_q.empty;
      if (indep) begin
        rd_fill_q <= wr_sync - rd_ptr_q;
      end else begin
        rd_fill_q <= tot_d;
      end
    end
  end

  // ==========================================================
  // Outputs, all straight from registers
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
  assign WR_FLAGS = wflags_q;
  assign WR_FILL = wr_fill_q;
  assign RD_FLAGS = rflags_q;
  assign RD_FILL = rd_fill_q;
  assign RD_DATA = rd_data_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST || !CORE_CE || flush_w);

  a_ack_on_write: assert property (
    WR_EN && !WR_FLAGS.full |=> WR_FLAGS.wr_ack && !WR_FLAGS.overflow)
    else $error("write accepted without acknowledge");

  a_ack_no_write: assert property (
    !WR_EN |=> !WR_FLAGS.wr_ack && !WR_FLAGS.overflow)
    else $error("write handshake moved without a write");

  a_overflow_full: assert property (
    WR_EN && WR_FLAGS.full |=> WR_FLAGS.overflow && !WR_FLAGS.wr_ack)
    else $error("write while full did not flag overflow");

  a_underflow_empty: assert property (
    RD_EN && RD_FLAGS.empty |=> RD_FLAGS.underflow && !RD_FLAGS.valid)
    else $error("read while empty did not flag underflow");

  a_valid_only_read: assert property (
    !RD_EN |=> !RD_FLAGS.valid && !RD_FLAGS.underflow)
    else $error("read handshake moved without a read");

  a_std_full_now: assert property (
    mode_q == FFU_MODE_STD && WR_EN && !WR_FLAGS.full && !RD_EN
      && fcnt_q == NEAR_FULL_CNT |=> WR_FLAGS.full)
    else $error("full late after filling write");

  // A read that takes the count just below the level clears it one edge late
  a_thr_full_lag: assert property (
    mode_q == FFU_MODE_STD && RD_EN && !WR_EN && !RD_FLAGS.empty
      && fcnt_q == thr_full_lvl_q
      |=> WR_FLAGS.thr_full ##1 !WR_FLAGS.thr_full)
    else $error("threshold full not one edge behind full");

  a_look_empty_two: assert property (
    look && WR_EN && !WR_FLAGS.full && tot_q == '0
      |=> RD_FLAGS.empty [*2] ##1 !RD_FLAGS.empty)
    else $error("lookahead empty not cleared two edges after write");

  // Single clock, so the extra crossing edge never appears here
  a_indep_full_lag: assert property (
    indep && RD_EN && !RD_FLAGS.empty && WR_FLAGS.full && rd_sync == rd_ptr_q
      |=> WR_FLAGS.full [*4] ##1 !WR_FLAGS.full)
    else $error("full released off the N+2 edge count");

  a_indep_empty_lag: assert property (
    // Only a write with none already in flight sets the full crossing count
    indep && WR_EN && !WR_FLAGS.full && RD_FLAGS.empty && tot_q == '0
      && wr_sync == wr_ptr_q
      |=> RD_FLAGS.empty [*4] ##1 !RD_FLAGS.empty)
    else $error("empty released off the N+2 edge count");

  c_look_read: cover property (look && RD_EN && !RD_FLAGS.empty);
  c_overflow: cover property (WR_FLAGS.overflow);
  c_indep_full: cover property (indep && WR_FLAGS.full ##1 !WR_FLAGS.full);
  c_thr_empty: cover property ($fell(RD_FLAGS.thr_empty));

endmodule

// file: ffu_pkg.sv
// Shared constants and types for the flag-timed soft FIFO.
// Assumes one clock; the independent-clock view is modelled by pointer synchronisers.
package ffu_pkg;

  // ==========================================================
  // Geometry
  localparam int DATA_W = 8;       // Word width
  localparam int ADDR_W = 4;       // RAM address width
  localparam int PTR_W = 5;        // Pointer and count width
  localparam int DEPTH = 16;       // RAM words
  localparam int SYNC_STAGES = 2;  // Crossing synchroniser stages

  // ==========================================================
  // Flag thresholds
  localparam logic [PTR_W-1:0] DEPTH_CNT = 5'h10;
  localparam logic [PTR_W-1:0] NEAR_FULL_CNT = 5'h0f;
  localparam logic [PTR_W-1:0] NEAR_EMPTY_CNT = 5'h01;
  localparam logic [PTR_W-1:0] THR_FULL_RST = 5'h0c;
  localparam logic [PTR_W-1:0] THR_EMPTY_RST = 5'h04;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_THRESH = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FILL = 8'h0c;

  // ==========================================================
  // Field positions
  localparam int MODE_LSB = 0;
  localparam int THR_FULL_LSB = 0;
  localparam int THR_EMPTY_LSB = 8;
  localparam int STAT_WFLAGS_LSB = 0;
  localparam int STAT_RFLAGS_LSB = 8;
  localparam int FILL_WR_LSB = 0;
  localparam int FILL_RD_LSB = 8;

  // ==========================================================
  // Operating modes, one-hot
  typedef enum logic [2:0] {
    FFU_MODE_STD = 3'h1,   // Common clock, standard read
    FFU_MODE_LOOK = 3'h2,  // Common clock, lookahead_read_mode
    FFU_MODE_INDEP = 3'h4  // Independent clocks, standard read
  } ffu_mode_type;

  // ==========================================================
  // Flag carriers
  typedef struct packed {
    logic full;
    logic near_full;
    logic thr_full;
    logic wr_ack;
    logic overflow;
  } ffu_wflags_type;

  typedef struct packed {
    logic empty;
    logic near_empty;
    logic thr_empty;
    logic valid;
    logic underflow;
  } ffu_rflags_type;

  localparam ffu_wflags_type WFLAGS_RST = 5'h00;
  localparam ffu_rflags_type RFLAGS_RST = 5'h18;  // Empty and near empty set

endpackage

// file: ffu_ptr_sync.sv
// Gray-coded pointer crossing with a chain of synchroniser stages.
// Assumes the source pointer moves by at most one per clock.
`timescale 1ns/1ps
module ffu_ptr_sync import ffu_pkg::*; (
  // Clock and control
  input wire logic clk,
  input wire logic clr,
  input wire logic ce,
  // Pointers
  input wire logic [PTR_W-1:0] ptr_bin,
  output logic [PTR_W-1:0] ptr_sync
);

  // ==========================================================
  // Source gray register and stage chain
  logic [PTR_W-1:0] gray_q;                   // Source-side gray copy
  logic [PTR_W-1:0] stage_q [SYNC_STAGES];    // Synchroniser chain
  logic [PTR_W-1:0] bin_w;                    // Decoded last stage

  // Gray encode so each sample is the old or the new pointer
  always_ff @(posedge clk) begin
    if (clr) begin
      gray_q <= '0;
    end else if (ce) begin
      gray_q <= ptr_bin ^ (ptr_bin >> 1);
    end
  end

  // Each stage is read only by the next, the last only by the gray decode
  for (genvar g = 0; g < SYNC_STAGES; g++) begin : g_stage
    always_ff @(posedge clk) begin
      if (clr) begin
        stage_q[g] <= '0;
      end else if (ce) begin
        if (g == 0) begin
          stage_q[g] <= gray_q;
        end else begin
          stage_q[g] <= stage_q[(g == 0) ? 0 : g-1];
        end
      end
    end
  end

  // Gray to binary on the settled stage
  always_comb begin
    bin_w[PTR_W-1] = stage_q[SYNC_STAGES-1][PTR_W-1];
    for (int i = PTR_W-2; i >= 0; i--) begin
      bin_w[i] = bin_w[i+1] ^ stage_q[SYNC_STAGES-1][i];
    end
  end

  // Registered binary view
  always_ff @(posedge clk) begin
    if (clr) begin
      ptr_sync <= '0;
    end else if (ce) begin
      ptr_sync <= bin_w;
    end
  end

endmodule

// file: ffu_ram.sv
// Distributed-style storage: registered write, combinational read.
// Assumes the caller never writes a full array.
`timescale 1ns/1ps
module ffu_ram import ffu_pkg::*; (
  // Clock
  input wire logic clk,
  input wire logic ce,
  // Write port
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  // Read port
  input wire logic [ADDR_W-1:0] raddr,
  output logic [DATA_W-1:0] rdata
);

  // ==========================================================
  // Storage
  logic [DATA_W-1:0] mem [DEPTH];  // Data only, no reset needed

  // Write on the clock
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read needs no clock so lookahead can prefetch
  assign rdata = mem[raddr];

endmodule

// file: ffu_user_model.sv
// User logic on the far side of the soft FIFO: a word producer and a word consumer.
// Assumes callers enter its tasks from procedural code; every change follows a rising edge.
`timescale 1ns/1ps
module ffu_user_model import ffu_pkg::*; (
  // Clock
  input wire logic clk,
  // Producer side
  output logic wr_en,
  output logic [DATA_W-1:0] wr_data,
  // Consumer side
  output logic rd_en
);
  // ==========================================================
  // Idle at time zero, so the core sees no request in reset
  initial begin
    wr_en = 1'b0;
    wr_data = 8'h00;
    rd_en = 1'b0;
  end

  // ==========================================================
  // Burst of n writes with rising data; strobe held across all taking edges
  task automatic push_n(input int n, input logic [DATA_W-1:0] base);
    @(posedge clk);
    wr_en <= 1'b1;
    for (int i = 0; i < n; i++) begin
      wr_data <= base + i[DATA_W-1:0];
      @(posedge clk);
    end
    wr_en <= 1'b0;
    // Released data is inverted so no stale word can pass for a real one
    wr_data <= ~(base + n[DATA_W-1:0]);
  endtask

  // ==========================================================
  // Burst of n reads; a read on an empty queue is allowed and answered
  task automatic pop_n(input int n);
    @(posedge clk);
    rd_en <= 1'b1;
    repeat (n) @(posedge clk);
    rd_en <= 1'b0;
  endtask
endmodule

// file: ffu_flag_core_tb.sv
// Self-checking bench for the soft FIFO flag timing in all three modes.
// Assumes ffu_pkg, the core and ffu_user_model are compiled before this file.
`timescale 1ns/1ps
module ffu_flag_core_tb import ffu_pkg::*;;
  // ==========================================================
  // Stimulus and observation
  logic core_clk;
  logic sys_rst, core_ce;
  logic cyc, stb, we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, wb_dat;
  logic wb_ack, wr_en, rd_en;
  logic [DATA_W-1:0] wr_data, rd_data;
  ffu_wflags_type wflags;
  ffu_rflags_type rflags;
  logic [PTR_W-1:0] wr_fill, rd_fill;
  int num_errors = 0, check_count = 0, k;

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  ffu_flag_core i_ffu_flag_core (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .CORE_CE(core_ce),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(wb_dat), .WB_ACK_O(wb_ack), .WR_EN(wr_en), .WR_DATA(wr_data),
    .WR_FLAGS(wflags), .WR_FILL(wr_fill), .RD_EN(rd_en), .RD_DATA(rd_data),
    .RD_FLAGS(rflags), .RD_FILL(rd_fill));
  ffu_user_model i_ffu_user_model (.clk(core_clk), .wr_en(wr_en), .wr_data(wr_data),
    .rd_en(rd_en));

  // ==========================================================
  // Verdict, reached from the main sequence and from any timeout
  task automatic close_out;
    $display("Checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Value comparison; case inequality so an unknown never matches
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single Wishbone cycle; waits for ack under a bound
  task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    r = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      close_out();
    end
  endtask

  // ==========================================================
  // Register port: status, thresholds, a read-only write, an unmapped address
  task automatic s_regs;
    wb_io(1'b0, REG_STATUS, 32'h0, rdat);
    chk("status", 32'h00001c00, rdat);
    wb_io(1'b0, REG_THRESH, 32'h0, rdat);
    chk("thresh", 32'h0000040c, rdat);
    wb_io(1'b1, REG_STATUS, 32'hffffffff, rdat);
    wb_io(1'b0, REG_STATUS, 32'h0, rdat);
    chk("status ro", 32'h00001c00, rdat);
    wb_io(1'b0, 8'h10, 32'h0, rdat);
    chk("unmapped", 32'h0, rdat);
    wb_io(1'b0, REG_FILL, 32'h0, rdat);
    chk("fill reg", 32'h0, rdat);
  endtask

  // Common clock, standard read: fill past full, then drain to empty
  task automatic s_std;
    i_ffu_user_model.pop_n(1);
    @(negedge core_clk);
    chk("underflow", 1, rflags.underflow);
    chk("ack on read", 0, wflags.wr_ack);
    i_ffu_user_model.push_n(1, 8'h10);
    @(negedge core_clk);
    chk("wflags first", 5'b00010, wflags);
    chk("rflags first", 5'b01100, rflags);
    chk("rd fill first", 1, rd_fill);
    i_ffu_user_model.push_n(11, 8'h11);
    @(negedge core_clk);
    chk("wflags at 12", 5'b00010, wflags);
    @(negedge core_clk);
    chk("thr full late", 1, wflags.thr_full);
    i_ffu_user_model.push_n(4, 8'h1c);
    @(negedge core_clk);
    chk("wflags full", 5'b11110, wflags);
    i_ffu_user_model.push_n(1, 8'hee);
    @(negedge core_clk);
    chk("wflags overflow", 5'b11101, wflags);
    i_ffu_user_model.pop_n(1);
    @(negedge core_clk);
    chk("wflags after read", 5'b01100, wflags);
    chk("rflags after read", 5'b00010, rflags);
    chk("first word", 8'h10, rd_data);
    chk("rd fill 15", 15, rd_fill);
    i_ffu_user_model.pop_n(4);
    @(negedge core_clk);
    chk("thr full held", 1, wflags.thr_full);
    chk("word 5", 8'h14, rd_data);
    @(negedge core_clk);
    chk("thr full cleared", 0, wflags.thr_full);
    i_ffu_user_model.pop_n(7);
    @(negedge core_clk);
    chk("thr empty held", 0, rflags.thr_empty);
    chk("word 12", 8'h1b, rd_data);
    @(negedge core_clk);
    chk("thr empty set", 1, rflags.thr_empty);
    i_ffu_user_model.pop_n(4);
    @(negedge core_clk);
    chk("rflags drained", 5'b11110, rflags);
    chk("last word", 8'h1f, rd_data);
    chk("rd fill 0", 0, rd_fill);
  endtask

  // Common clock, lookahead read: empty falls two edges after the write
  task automatic s_look;
    wb_io(1'b1, REG_CTRL, 32'h2, rdat);
    i_ffu_user_model.push_n(1, 8'ha5);
    @(negedge core_clk);
    chk("look fill", 1, rd_fill);
    chk("look empty e0", 1, rflags.empty);
    @(negedge core_clk);
    chk("look empty e1", 1, rflags.empty);
    @(negedge core_clk);
    chk("look empty e2", 0, rflags.empty);
    chk("look word", 8'ha5, rd_data);
    i_ffu_user_model.pop_n(1);
    @(negedge core_clk);
    chk("look rflags", 5'b11110, rflags);
    chk("look fill 0", 0, rd_fill);
    i_ffu_user_model.pop_n(1);
    @(negedge core_clk);
    chk("look underflow", 1, rflags.underflow);
  endtask

  // Independent clocks: local flags at once, the far side after the crossing
  task automatic s_indep;
    wb_io(1'b1, REG_CTRL, 32'h4, rdat);
    i_ffu_user_model.push_n(1, 8'h5a);
    @(negedge core_clk);
    chk("indep wflags", 5'b00010, wflags);
    chk("indep wr fill e0", 0, wr_fill);
    @(negedge core_clk);
    chk("indep wr fill e1", 1, wr_fill);
    k = 1;
    while (rflags.empty !== 1'b0 && k < 12) begin
      @(negedge core_clk);
      k++;
    end
    chk("empty lag", 1, 32'(k == 4 || k == 5));
    i_ffu_user_model.pop_n(1);
    @(negedge core_clk);
    chk("indep valid", 1, rflags.valid);
    chk("indep word", 8'h5a, rd_data);
    @(negedge core_clk);
    chk("indep rd fill", 0, rd_fill);
    k = 1;
    while (wr_fill !== 5'h00 && k < 12) begin
      @(negedge core_clk);
      k++;
    end
    chk("wr fill lag", 1, 32'(k == 4 || k == 5));
    // Fill to full, then time the release of full across the crossing
    i_ffu_user_model.push_n(16, 8'h60);
    @(negedge core_clk);
    chk("indep full", 5'b11110, wflags);
    i_ffu_user_model.pop_n(1);
    @(negedge core_clk);
    k = 0;
    while (wflags.full !== 1'b0 && k < 12) begin
      @(negedge core_clk);
      k++;
    end
    chk("full lag", 1, 32'(k == 4 || k == 5));
  endtask

  // Clock enable low: writes are ignored and every write-side flag holds
  task automatic s_freeze;
    @(posedge core_clk);
    core_ce <= 1'b0;
    i_ffu_user_model.push_n(2, 8'h70);
    @(posedge core_clk);
    core_ce <= 1'b1;
    @(negedge core_clk);
    chk("frozen wflags", 5'b01100, wflags);
    chk("frozen fill", 15, wr_fill);
  endtask

  // ==========================================================
  // Main sequence: 16 cycles of reset, then each scenario in turn
  initial begin
    // Idle bus and reset asserted from time zero
    core_clk = 1'b0;
    sys_rst = 1'b1;
    core_ce = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    s_regs();
    s_std();
    s_look();
    s_indep();
    s_freeze();
    close_out();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    close_out();
  end
endmodule
